/* adc_mode_control.sv */
// serial command decode, conversion sequencing and power modes of the adc
`timescale 1ns/100ps
`include "adc_mode_params.svh"
module adc_mode_control
    import adc_mode_pkg::*;
#(
    parameter int INT_CLK_DIV = 2,
    parameter int CONV_TICKS  = 16,
    parameter int DATA_W      = 14
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic              din,
    input  wire logic [DATA_W-1:0] conv_data,
    output logic                   dout,
    output logic                   conversion_done_strobe,
    output logic                   operating_mode_bit_high,
    output logic                   operating_mode_bit_mid,
    output logic                   operating_mode_bit_low,
    output logic                   analog_powered,
    output logic                   reference_powered,
    output logic                   channel_defaults_load,
    output logic                   sample_hold
);
    // ---------------- sclk domain ----------------
    logic              started_reg,  started_next;
    logic [4:0]        fcnt_reg,     fcnt_next;
    logic [4:0]        bcnt_reg,     bcnt_next;
    logic [7:0]        word_reg,     word_next;
    logic [7:0]        cmd_hold_reg, cmd_hold_next;
    logic              cmd_tgl_reg,  cmd_tgl_next;
    logic              start_tgl_reg, start_tgl_next;
    logic              acq_tgl_reg,  acq_tgl_next;
    logic              icm_tgl_reg,  icm_tgl_next;
    logic [DATA_W-1:0] sh_reg,       sh_next;
    logic              dout_reg,     dout_next;
    logic              rd_reg,       rd_next;
    logic [4:0]        ctl_s;
    logic [DATA_W-1:0] data_sclk_s;
    logic [DATA_W-1:0] result_reg,   result_next;
    logic              conv_word;
    logic [2:0]        mode_s;

    // ctl_s = {strobe, powered, mode}; quasi-static between frames
    assign mode_s    = ctl_s[2:0];
    assign conv_word = started_reg && (bcnt_reg >= `CMD_BITS) && (word_reg[3:0] != `MODE_TAG) && ctl_s[3];

    always_comb begin
        started_next   = started_reg;
        fcnt_next      = fcnt_reg;
        bcnt_next      = bcnt_reg;
        word_next      = word_reg;
        cmd_hold_next  = cmd_hold_reg;
        cmd_tgl_next   = cmd_tgl_reg;
        start_tgl_next = start_tgl_reg;
        if (fcnt_reg != `CNT_MAX) begin
            fcnt_next = fcnt_reg + 5'h01;
        end
        if (!started_reg) begin
            if (din) begin
                started_next   = 1'b1;
                bcnt_next      = 5'h01;
                word_next      = 8'h01;
                start_tgl_next = ~start_tgl_reg;
            end
        end else begin
            if (bcnt_reg != `CNT_MAX) begin
                bcnt_next = bcnt_reg + 5'h01;
            end
            if (bcnt_reg < `CMD_BITS) begin
                word_next = {word_reg[6:0], din};
            end
            if (bcnt_reg == `CMD_BITS - 5'h01) begin
                cmd_hold_next = {word_reg[6:0], din};
                cmd_tgl_next  = ~cmd_tgl_reg;
            end
        end
    end

    // frame state ends with the frame: cs high clears it without any sclk edge
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            started_reg <= 1'b0;
            fcnt_reg    <= 5'h00;
            bcnt_reg    <= 5'h00;
            word_reg    <= 8'h00;
        end else begin
            started_reg <= started_next;
            fcnt_reg    <= fcnt_next;
            bcnt_reg    <= bcnt_next;
            word_reg    <= word_next;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            cmd_hold_reg  <= 8'h00;
            cmd_tgl_reg   <= 1'b0;
            start_tgl_reg <= 1'b0;
        end else begin
            cmd_hold_reg  <= cmd_hold_next;
            cmd_tgl_reg   <= cmd_tgl_next;
            start_tgl_reg <= start_tgl_next;
        end
    end

    always_comb begin
        sh_next      = sh_reg;
        dout_next    = dout_reg;
        rd_next      = rd_reg;
        acq_tgl_next = acq_tgl_reg;
        icm_tgl_next = icm_tgl_reg;
        if (conv_word && bcnt_reg == `EXT_SAMPLE_EDGE && mode_s == MODE_EXT_CLK) begin
            dout_next = data_sclk_s[DATA_W-1];
            sh_next   = {data_sclk_s[DATA_W-2:0], 1'b0};
            rd_next   = 1'b1;
        end else if (!rd_reg && ctl_s[4] && fcnt_reg == `RD_LOAD_EDGE) begin
            // load waits two rising edges so the synchronised strobe is fresh
            dout_next = result_reg[DATA_W-1];
            sh_next   = {result_reg[DATA_W-2:0], 1'b0};
            rd_next   = 1'b1;
        end else if (rd_reg) begin
            dout_next = sh_reg[DATA_W-1];
            sh_next   = {sh_reg[DATA_W-2:0], 1'b0};
        end
        if (conv_word && bcnt_reg == `ACQ_SAMPLE_EDGE && mode_s == MODE_EXT_ACQ) begin
            acq_tgl_next = ~acq_tgl_reg;
        end
        if (conv_word && bcnt_reg == `ICM_START_EDGE && mode_s == MODE_INT_CLK) begin
            icm_tgl_next = ~icm_tgl_reg;
        end
    end

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            sh_reg   <= '0;
            dout_reg <= 1'b0;
            rd_reg   <= 1'b0;
        end else begin
            sh_reg   <= sh_next;
            dout_reg <= dout_next;
            rd_reg   <= rd_next;
        end
    end

    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            acq_tgl_reg <= 1'b0;
            icm_tgl_reg <= 1'b0;
        end else begin
            acq_tgl_reg <= acq_tgl_next;
            icm_tgl_reg <= icm_tgl_next;
        end
    end

    // ---------------- ref_clk domain ----------------
    logic [3:0]        evt_s;
    logic [3:0]        evt_d_reg;
    logic [DATA_W-1:0] data_ref_s;
    logic              word_evt, start_evt, acq_evt, icm_evt, tick, done_evt;
    logic [2:0]        field;
    mode_e             mode_reg,    mode_next;
    pwr_e              pwr_reg,     pwr_next;
    conv_e             st_reg,      st_next;
    logic [2:0]        cyc_reg,     cyc_next;
    logic [3:0]        div_reg,     div_next;
    logic [4:0]        tcnt_reg,    tcnt_next;
    logic [DATA_W-1:0] samp_reg,    samp_next;
    logic              strobe_reg,  strobe_next;
    logic              dflt_reg,    dflt_next;
    logic              sample_reg,  sample_next;
    logic              apwr_reg,    rpwr_reg;

    bit_sync #(.W(4)) u_evt_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   ({icm_tgl_reg, acq_tgl_reg, start_tgl_reg, cmd_tgl_reg}),
        .q   (evt_s)
    );
    bit_sync #(.W(DATA_W)) u_data_ref_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   (conv_data),
        .q   (data_ref_s)
    );
    bit_sync #(.W(DATA_W)) u_data_sclk_sync (
        .clk (sclk),
        .rst (rst),
        .d   (conv_data),
        .q   (data_sclk_s)
    );
    bit_sync #(.W(5)) u_ctl_sync (
        .clk (sclk),
        .rst (rst),
        .d   ({strobe_reg, pwr_reg == PWR_ON, mode_reg}),
        .q   (ctl_s)
    );

    assign word_evt  = evt_s[0] ^ evt_d_reg[0];
    assign start_evt = evt_s[1] ^ evt_d_reg[1];
    assign acq_evt   = evt_s[2] ^ evt_d_reg[2];
    assign icm_evt   = evt_s[3] ^ evt_d_reg[3];
    assign field     = cmd_hold_reg[`MODE_FIELD_HI:`MODE_FIELD_LO];
    assign tick      = div_reg == 4'(INT_CLK_DIV - 1);
    assign result_next = done_evt ? samp_reg : result_reg;

    always_comb begin
        mode_next   = mode_reg;
        pwr_next    = pwr_reg;
        st_next     = st_reg;
        cyc_next    = cyc_reg;
        div_next    = 4'h0;
        tcnt_next   = tcnt_reg;
        samp_next   = samp_reg;
        strobe_next = strobe_reg;
        dflt_next   = 1'b0;
        sample_next = 1'b0;
        done_evt    = 1'b0;
        if (start_evt) begin
            strobe_next = 1'b0;
        end
        if (word_evt && cmd_hold_reg[3:0] == `MODE_TAG) begin
            unique case (field)
                `CODE_EXT_CLK, `CODE_EXT_ACQ, `CODE_INT_CLK: begin
                    mode_next = mode_e'(field);
                    pwr_next  = PWR_ON;
                end
                `CODE_RESET: begin
                    mode_next = MODE_EXT_CLK;
                    pwr_next  = PWR_ON;
                    dflt_next = 1'b1;
                end
                `CODE_PARTIAL_PD: pwr_next = PWR_PARTIAL;
                `CODE_FULL_PD:    pwr_next = PWR_FULL;
                default: ;
            endcase
        end
        if (st_reg == S_ICM_ACQ || st_reg == S_CONV) begin
            div_next = tick ? 4'h0 : div_reg + 4'h1;
        end
        unique case (st_reg)
            S_IDLE: begin
                if (acq_evt && mode_reg == MODE_EXT_ACQ && pwr_reg == PWR_ON) begin
                    samp_next   = data_ref_s;
                    sample_next = 1'b1;
                    st_next     = S_CONV;
                    tcnt_next   = 5'h00;
                end else if (icm_evt && mode_reg == MODE_INT_CLK && pwr_reg == PWR_ON) begin
                    st_next  = S_ICM_WAIT;
                    cyc_next = 3'h0;
                end
            end
            S_ICM_WAIT: begin
                cyc_next = cyc_reg + 3'h1;
                if (cyc_reg == 3'(`START_CYC - 1)) begin
                    st_next   = S_ICM_ACQ;
                    tcnt_next = 5'h00;
                end
            end
            S_ICM_ACQ: begin
                if (tick) begin
                    tcnt_next = tcnt_reg + 5'h01;
                    if (tcnt_reg == `ICM_SAMPLE_TICK - 5'h01) begin
                        samp_next   = data_ref_s;
                        sample_next = 1'b1;
                        st_next     = S_CONV;
                        tcnt_next   = 5'h00;
                    end
                end
            end
            S_CONV: begin
                if (tick) begin
                    tcnt_next = tcnt_reg + 5'h01;
                    if (tcnt_reg == 5'(CONV_TICKS - 1)) begin
                        done_evt    = 1'b1;
                        strobe_next = 1'b1;
                        st_next     = S_IDLE;
                    end
                end
            end
        endcase
        // a mode or power change abandons any conversion in flight
        if (pwr_next != PWR_ON || mode_next != mode_reg) begin
            st_next = S_IDLE;
        end
        if (mode_next == MODE_EXT_CLK) begin
            strobe_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            evt_d_reg  <= 4'h0;
            mode_reg   <= MODE_EXT_CLK;
            pwr_reg    <= PWR_ON;
            st_reg     <= S_IDLE;
            cyc_reg    <= 3'h0;
            div_reg    <= 4'h0;
            tcnt_reg   <= 5'h00;
            samp_reg   <= '0;
            result_reg <= '0;
            strobe_reg <= 1'b0;
            dflt_reg   <= 1'b1;
            sample_reg <= 1'b0;
            apwr_reg   <= 1'b1;
            rpwr_reg   <= 1'b1;
        end else begin
            evt_d_reg  <= evt_s;
            mode_reg   <= mode_next;
            pwr_reg    <= pwr_next;
            st_reg     <= st_next;
            cyc_reg    <= cyc_next;
            div_reg    <= div_next;
            tcnt_reg   <= tcnt_next;
            samp_reg   <= samp_next;
            result_reg <= result_next;
            strobe_reg <= strobe_next;
            dflt_reg   <= dflt_next;
            sample_reg <= sample_next;
            apwr_reg   <= pwr_next == PWR_ON;
            rpwr_reg   <= pwr_next != PWR_FULL;
        end
    end

    assign dout                    = dout_reg;
    assign conversion_done_strobe  = strobe_reg;
    assign operating_mode_bit_high = mode_reg[2];
    assign operating_mode_bit_mid  = mode_reg[1];
    assign operating_mode_bit_low  = mode_reg[0];
    assign analog_powered          = apwr_reg;
    assign reference_powered       = rpwr_reg;
    assign channel_defaults_load   = dflt_reg;
    assign sample_hold             = sample_reg;

    // ---------------- checks ----------------
    a_strobe_ext_low: assert property (@(posedge ref_clk) disable iff (rst)
        mode_reg == MODE_EXT_CLK |-> !conversion_done_strobe)
        else $error("strobe high in external clock mode");
    a_strobe_rise: assert property (@(posedge ref_clk) disable iff (rst)
        (st_reg == S_CONV && tick && tcnt_reg == 5'(CONV_TICKS - 1) && !word_evt) |=> conversion_done_strobe)
        else $error("strobe not raised at conversion end");
    a_strobe_fall: assert property (@(posedge ref_clk) disable iff (rst)
        (start_evt && !done_evt) |=> !conversion_done_strobe)
        else $error("strobe not cleared by start bit");
    a_reset_defaults: assert property (@(posedge ref_clk) disable iff (rst)
        (word_evt && cmd_hold_reg[3:0] == `MODE_TAG && field == `CODE_RESET)
        |=> (mode_reg == MODE_EXT_CLK && analog_powered && channel_defaults_load))
        else $error("reset code did not restore defaults");
    a_reserved_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (word_evt && cmd_hold_reg[3:0] == `MODE_TAG && (field == 3'h3 || field == 3'h5))
        |=> ($stable(mode_reg) && $stable(pwr_reg)))
        else $error("reserved code changed the mode");
    a_partial_entry: assert property (@(posedge ref_clk) disable iff (rst)
        (word_evt && cmd_hold_reg[3:0] == `MODE_TAG && field == `CODE_PARTIAL_PD)
        |=> (!analog_powered && reference_powered))
        else $error("partial power-down not entered");
    a_full_entry: assert property (@(posedge ref_clk) disable iff (rst)
        (word_evt && cmd_hold_reg[3:0] == `MODE_TAG && field == `CODE_FULL_PD)
        |=> (!analog_powered && !reference_powered))
        else $error("full power-down not entered");
    a_pd_no_wake: assert property (@(posedge ref_clk) disable iff (rst)
        (pwr_reg != PWR_ON && !word_evt) |=> $stable(pwr_reg))
        else $error("power-down left without a mode word");
    a_icm_start: assert property (@(posedge ref_clk) disable iff (rst)
        (st_reg == S_IDLE && icm_evt && !acq_evt && !word_evt && mode_reg == MODE_INT_CLK && pwr_reg == PWR_ON)
        |=> st_reg == S_ICM_WAIT [*2] ##1 st_reg == S_ICM_ACQ)
        else $error("internal clock start delay wrong");
endmodule // adc_mode_control

/* adc_mode_control_and_power_modes_test.sv */
// self-checking bench for adc mode control and power modes
`timescale 1ns/100ps
module adc_mode_control_and_power_modes_test
    import adc_mode_pkg::*;
;
    logic        ref_clk;
    logic        rst;
    logic [13:0] conv_data;
    logic [31:0] rx;
    logic [2:0]  exp_mode;
    logic        exp_an;
    logic        exp_rf;
    wire         sclk;
    wire         cs_n;
    wire         din;
    wire         dout;
    wire         strobe;
    wire         m_hi;
    wire         m_mid;
    wire         m_lo;
    wire         analog_powered;
    wire         reference_powered;
    wire         channel_defaults_load;
    wire         sample_hold;
    wire [2:0]   mode_bits = {m_hi, m_mid, m_lo};
    int          mismatches = 0;
    int          checks_done = 0;
    int          sh_cnt = 0;
    int          def_cnt = 0;
    int          codes[14] = '{1, 6, 3, 7, 5, 2, 4, 0, 6, 0, 7, 4, 3, 5};

    host_serial_model u_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

    adc_mode_control u_dut (
        .ref_clk                 (ref_clk),
        .rst                     (rst),
        .sclk                    (sclk),
        .cs_n                    (cs_n),
        .din                     (din),
        .conv_data               (conv_data),
        .dout                    (dout),
        .conversion_done_strobe  (strobe),
        .operating_mode_bit_high (m_hi),
        .operating_mode_bit_mid  (m_mid),
        .operating_mode_bit_low  (m_lo),
        .analog_powered          (analog_powered),
        .reference_powered       (reference_powered),
        .channel_defaults_load   (channel_defaults_load),
        .sample_hold             (sample_hold)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // pulse counters; baselines taken before each step, so reset-time counts do not matter
    always @(posedge ref_clk) begin
        if (sample_hold === 1'b1) sh_cnt++;
        if (channel_defaults_load === 1'b1) def_cnt++;
    end

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic wait_ref(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic mode_word(input logic [2:0] c);
        u_host.frame({1'b1, c, 4'h8}, 8, rx);
        wait_ref(8);
    endtask

    task automatic check_data(input int first);
        logic [13:0] got;
        for (int k = 0; k < 14; k++) got[13-k] = rx[first+k];
        check(got === conv_data, "result bits differ");
    endtask

    // bounded wait for conversion done
    task automatic wait_strobe();
        int n;
        n = 0;
        while (strobe !== 1'b1 && n < 300) begin
            wait_ref(1);
            n++;
        end
        check(strobe === 1'b1, "conversion done never rose");
    endtask

    task automatic test_done();
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #1_000_000;
        mismatches++;
        $display("ERROR %0t watchdog expired", $time);
        test_done();
    end

    initial begin
        int d0;
        int s0;
        rst = 1'b1;
        conv_data = '0;
        void'($urandom(32'he217));
        wait_ref(12);
        check(channel_defaults_load === 1'b1, "defaults not loading in reset");
        rst = 1'b0;
        wait_ref(4);
        exp_mode = 3'h0;
        exp_an = 1'b1;
        exp_rf = 1'b1;
        check(mode_bits === 3'h0 && analog_powered === 1'b1, "power-up state");
        check(reference_powered === 1'b1 && strobe === 1'b0, "power-up outputs");
        // every code, reserved ones included, against the reference model
        foreach (codes[i]) begin
            d0 = def_cnt;
            mode_word(codes[i][2:0]);
            case (codes[i])
                0, 1, 2: begin
                    exp_mode = codes[i][2:0];
                    exp_an = 1'b1;
                    exp_rf = 1'b1;
                end
                4: begin
                    exp_mode = 3'h0;
                    exp_an = 1'b1;
                    exp_rf = 1'b1;
                end
                6: exp_an = 1'b0;
                7: begin
                    exp_an = 1'b0;
                    exp_rf = 1'b0;
                end
                default: ;
            endcase
            check(mode_bits === exp_mode, "mode field");
            check(analog_powered === exp_an && reference_powered === exp_rf, "power state");
            check((def_cnt - d0) == ((codes[i] == 4) ? 1 : 0), "defaults reload");
            if (codes[i] >= 6) begin
                s0 = sh_cnt;
                u_host.glitch();
                u_host.frame(8'h80, 16, rx);
                wait_ref(60);
                check(analog_powered === exp_an && reference_powered === exp_rf, "woken");
                check(sh_cnt == s0 && mode_bits === exp_mode, "converted while down");
            end
        end
        // one conversion in each mode with a random value
        for (int m = 0; m < 3; m++) begin
            conv_data = 14'($urandom);
            mode_word(m[2:0]);
            check(strobe === 1'b0, "done not cleared by start bit");
            s0 = sh_cnt;
            u_host.frame(8'h80 | 8'($urandom & 32'h77), (m == 0) ? 28 : (m == 1) ? 16 : 8, rx);
            if (m == 0) begin
                wait_ref(40);
                check_data(14);
                check(strobe === 1'b0 && sh_cnt == s0, "strobe in external clock");
            end else begin
                wait_strobe();
                check(sh_cnt == s0 + 1, "one sample instant");
                u_host.frame(8'h00, 16, rx);
                wait_ref(4);
                check_data(2);
                check(strobe === 1'b1, "strobe dropped without start bit");
            end
        end
        mode_word(3'h0);
        check(strobe === 1'b0, "done not cleared by start bit");
        test_done();
    end

endmodule // adc_mode_control_and_power_modes_test

/* adc_mode_params.svh */
// timing, field and code constants of the adc mode control block
`ifndef ADC_MODE_PARAMS_SVH
`define ADC_MODE_PARAMS_SVH

`define CMD_BITS          5'h08
`define START_FIELD_BIT   7
`define MODE_FIELD_HI     6
`define MODE_FIELD_LO     4
`define MODE_TAG          4'h8
`define CODE_EXT_CLK      3'h0
`define CODE_EXT_ACQ      3'h1
`define CODE_INT_CLK      3'h2
`define CODE_RESET        3'h4
`define CODE_PARTIAL_PD   3'h6
`define CODE_FULL_PD      3'h7
`define EXT_SAMPLE_EDGE   5'h0e
`define ACQ_SAMPLE_EDGE   5'h10
`define ICM_START_EDGE    5'h08
`define RD_LOAD_EDGE      5'h02
`define CNT_MAX           5'h1f
`define REF_CLK_NS        100
`define START_DLY_NS      200
`define START_CYC         ((`START_DLY_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)
`define ICM_SAMPLE_TICK   5'h0b

`endif

/* adc_mode_pkg.sv */
// types shared by the adc mode control block
package adc_mode_pkg;

    typedef enum logic [2:0] {
        MODE_EXT_CLK = 3'h0,
        MODE_EXT_ACQ = 3'h1,
        MODE_INT_CLK = 3'h2
    } mode_e;

    typedef enum logic [1:0] {
        PWR_ON      = 2'h0,
        PWR_PARTIAL = 2'h1,
        PWR_FULL    = 2'h2
    } pwr_e;

    typedef enum logic [1:0] {
        S_IDLE     = 2'h0,
        S_ICM_WAIT = 2'h1,
        S_ICM_ACQ  = 2'h2,
        S_CONV     = 2'h3
    } conv_e;

endpackage

/* bit_sync.sv */
// two flip-flop synchroniser for a vector of levels or toggles
`timescale 1ns/100ps
module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // async clear so it works for a clock that may stand still during reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= d;
            q_reg    <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule // bit_sync

/* host_serial_model.sv */
// serial host master that drives the adc command link
`timescale 1ns/100ps
module host_serial_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout
);

    // link clock stands still low outside frames
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // one frame of ncyc sclk cycles; dout captured after each falling edge
    task automatic frame(input logic [7:0] cmd, input int ncyc, output logic [31:0] rx);
        rx   = '0;
        cs_n = 1'b0;
        #6;
        for (int i = 1; i <= ncyc; i++) begin
            din = (i <= 8) ? cmd[8-i] : 1'b0;
            #5 sclk = 1'b1;
            #6 sclk = 1'b0;
            #1 rx[i] = dout;
        end
        #5;
        cs_n = 1'b1;
        din  = ~din;
    endtask

    // chip select pulse with no clock, must not wake a powered-down part
    task automatic glitch();
        cs_n = 1'b0;
        #20 cs_n = 1'b1;
        #20;
    endtask

endmodule // host_serial_model
